// >>> hw/pmon_evt_counter.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pmon_regs.svh"

module pmon_evt_counter
  import pmon_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 48
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  output logic [31:0] RDATA_O,
  input wire evt_bus_t EV_I,
  output logic [NUM_CTR-1:0] OVF_O
);
  localparam int FIX = NUM_CTR - 1;

  function automatic logic is_ctl(input logic [ADDR_W-1:0] a, input int n);
    logic [ADDR_W-1:0] o;
    o = (n == FIX) ? ADDR_W'(`OFS_FIX_CTL) : ADDR_W'(`OFS_CTL0 + 4 * n);
    return a == o;
  endfunction : is_ctl

  function automatic logic is_ctr(input logic [ADDR_W-1:0] a, input int n, input logic hi);
    logic [ADDR_W-1:0] o;
    o = (n == FIX) ? ADDR_W'(`OFS_FIX_LO) : ADDR_W'(`OFS_CTR_BASE + 8 * n);
    return a == (o + (hi ? ADDR_W'(4) : ADDR_W'(0)));
  endfunction : is_ctr

  top_st_t st_r, st_nxt;
  logic [NUM_CTR-1:0][CNT_W-1:0] cnt;
  logic [NUM_CTR-1:0][7:0] inc;
  logic [NUM_CTR-1:0] clr;
  logic [NUM_CTR-1:0] wr_lo;
  logic [NUM_CTR-1:0] wr_hi;

  genvar g;
  generate
    for (g = 0; g < NUM_CTR; g++) begin : g_ctr
      if (g < FIX) begin : g_gen
        pmon_evt_select u_sel (
          .ev_i(EV_I),
          .code_i(st_r.ctl[g][`CTL_EVT_MSB:`CTL_EVT_LSB]),
          .umask_i(st_r.ctl[g][`CTL_UMASK_MSB:`CTL_UMASK_LSB]),
          .inc_o(inc[g])
        );
      end else begin : g_fix
        // Fixed counter ticks once per controller cycle, never on events
        assign inc[g] = 8'h01;
      end
      assign clr[g] = WE_I && is_ctl(ADDR_I, g) && WDATA_I[`CTL_RST_BIT];
      assign wr_lo[g] = WE_I && is_ctr(ADDR_I, g, 1'b0);
      assign wr_hi[g] = WE_I && is_ctr(ADDR_I, g, 1'b1);
      pmon_ctr_unit #(
        .CNT_W(CNT_W),
        .INC_W(8)
      ) u_ctr (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .en_i(st_r.ctl[g][`CTL_EN_BIT]),
        .ovf_req_en_i(st_r.ctl[g][`CTL_OVEN_BIT]),
        .clr_i(clr[g]),
        .wr_lo_i(wr_lo[g]),
        .wr_hi_i(wr_hi[g]),
        .wdata_i(WDATA_I),
        .inc_i(inc[g]),
        .cnt_o(cnt[g]),
        .ovf_o(OVF_O[g])
      );
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    if (WE_I) begin
      for (int n = 0; n < NUM_CTR; n++) begin
        if (is_ctl(ADDR_I, n)) begin
          // Clear bit is write-only and is never stored
          st_nxt.ctl[n] = WDATA_I & ((n == FIX) ? `CTL_FIX_MASK : `CTL_GEN_MASK);
        end
      end
    end
    if (RE_I) begin
      st_nxt.rdata = 32'h0000_0000;
      for (int n = 0; n < NUM_CTR; n++) begin
        if (is_ctl(ADDR_I, n)) begin
          st_nxt.rdata = st_r.ctl[n];
        end else if (is_ctr(ADDR_I, n, 1'b0)) begin
          st_nxt.rdata = cnt[n][31:0];
        end else if (is_ctr(ADDR_I, n, 1'b1)) begin
          st_nxt.rdata = {16'h0000, cnt[n][CNT_W-1:32]};
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA_O = st_r.rdata;
endmodule : pmon_evt_counter

// >>> hw/pmon_regs.svh
`ifndef PMON_REGS_SVH
`define PMON_REGS_SVH

// Register byte offsets
`define OFS_CTL0 8'h00
`define OFS_FIX_CTL 8'h10
`define OFS_CTR_BASE 8'h20
`define OFS_FIX_LO 8'h40
`define OFS_FIX_HI 8'h44

// Control word fields
`define CTL_EVT_LSB 0
`define CTL_EVT_MSB 7
`define CTL_UMASK_LSB 8
`define CTL_UMASK_MSB 15
`define CTL_RST_BIT 19
`define CTL_OVEN_BIT 20
`define CTL_EN_BIT 22
`define CTL_GEN_MASK 32'h0050_FFFF
`define CTL_FIX_MASK 32'h0050_0000
`define CTL_RESET_VAL 32'h0000_0000
`define CTR_RESET_VAL 48'h0000_0000_0000
`define CTR_HI_W 16

// Event codes
`define EV_ACT 8'h02
`define EV_PRE 8'h03
`define EV_CAS 8'h05
`define EV_MAJOR_MODES 8'h07
`define EV_PREEMPT 8'h08
`define EV_WQ_FULL1 8'h16
`define EV_RDB_INS 8'h17
`define EV_WQ_ALLOC 8'h20
`define EV_WQ_NE 8'h21
`define EV_WQ_FULL0 8'h22
`define EV_WQ_RD_MATCH 8'h23
`define EV_WQ_WR_MATCH 8'h24
`define EV_ACT_BY_PRIO 8'h28
`define EV_SELF_REF 8'h43
`define EV_PRE_ALL 8'h44
`define EV_REFRESH 8'h45
`define EV_THROTTLE 8'h46
`define EV_CKE_ON 8'h47
`define EV_MODE_CHG0 8'h50
`define EV_MODE_CHG1 8'h51
`define EV_RQ_OCC0 8'h80
`define EV_RQ_OCC1 8'h81
`define EV_WQ_OCC0 8'h82
`define EV_WQ_OCC1 8'h83
`define EV_PPD 8'h85
`define EV_CRIT_THR 8'h86
`define EV_SB_NE 8'hD0
`define EV_SB_FULL 8'hD1
`define EV_SB_ACC 8'hD2
`define EV_SB_REJ 8'hD4
`define EV_SB_OCC 8'hD5
`define EV_SB_INS 8'hD6
`define EV_SB_PF_INS 8'hDA
`define EV_SB_PF_OCC 8'hDB
`define EV_PM_RQ_OCC 8'hE0
`define EV_PM_RQ_NE 8'hE1
`define EV_PM_RQ_FULL 8'hE2
`define EV_PM_RQ_INS 8'hE3
`define EV_PM_WQ_OCC 8'hE4
`define EV_PM_WQ_NE 8'hE5
`define EV_PM_WQ_FULL 8'hE6
`define EV_PM_WQ_INS 8'hE7
`define EV_PM_WQ_FLUSH 8'hE8

`endif

// >>> hw/pmon_pkg.sv
package pmon_pkg;
  localparam int OCC_W = 6;
  localparam int NUM_CTR = 5;

  typedef enum logic [1:0] {
    PRIO_NORMAL,
    PRIO_CRITICAL,
    PRIO_STARVED
  } prio_t;

  typedef struct packed {
    logic act_rd;
    logic act_wr;
    logic act_uf;
    prio_t activate_by_priority;
    logic [5:0] cas;
    logic pre;
    logic pre_all;
    logic wq_full;
    logic [OCC_W-1:0] rq_occ;
    logic [OCC_W-1:0] wq_occ;
    logic [7:0] mode_chg;
  } pch_ev_t;

  typedef struct packed {
    pch_ev_t [1:0] pch;
    logic wq_alloc;
    logic wq_ne;
    logic rd_match;
    logic wr_match;
    logic [7:0] refresh;
    logic self_ref;
    logic [7:0] throttle;
    logic crit_throttle;
    logic [7:0] cke_on;
    logic ppd;
    logic [3:0] major_mode;
    logic rdb_insert;
    logic preempt;
    logic sb_ne;
    logic sb_full;
    logic sb_access;
    logic sb_refused;
    logic [OCC_W-1:0] sb_occ;
    logic sb_insert;
    logic sb_pref_insert;
    logic [OCC_W-1:0] sb_pref_occ;
    logic [OCC_W-1:0] pm_rq_occ;
    logic pm_rq_ne;
    logic pm_rq_full;
    logic pm_rq_ins;
    logic [OCC_W-1:0] pm_wq_occ;
    logic pm_wq_ne;
    logic pm_wq_full;
    logic pm_wq_ins;
    logic pm_wq_flush;
  } evt_bus_t;

  typedef struct packed {
    logic [47:0] cnt;
    logic ovf;
  } ctr_st_t;

  typedef struct packed {
    logic [NUM_CTR-1:0][31:0] ctl;
    logic [31:0] rdata;
  } top_st_t;
endpackage : pmon_pkg

// >>> hw/pmon_ctr_unit.sv
`timescale 1ns/1ps
`include "pmon_regs.svh"

module pmon_ctr_unit
  import pmon_pkg::*;
#(
  parameter int CNT_W = 48,
  parameter int INC_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic ovf_req_en_i,
  input wire logic clr_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [31:0] wdata_i,
  input wire logic [INC_W-1:0] inc_i,
  output logic [CNT_W-1:0] cnt_o,
  output logic ovf_o
);
  ctr_st_t st_r, st_nxt;
  logic [CNT_W:0] sum;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ovf = 1'b0;
    sum = {1'b0, st_r.cnt} + (CNT_W + 1)'(inc_i);
    if (wr_lo_i) begin
      st_nxt.cnt[31:0] = wdata_i;
    end else if (wr_hi_i) begin
      st_nxt.cnt[CNT_W-1:32] = wdata_i[`CTR_HI_W-1:0];
    end else if (clr_i) begin
      st_nxt.cnt = `CTR_RESET_VAL;
    end else if (en_i) begin
      // Carry out of the top bit is the wrap point
      st_nxt.cnt = sum[CNT_W-1:0];
      st_nxt.ovf = sum[CNT_W] & ovf_req_en_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt_o = st_r.cnt;
  assign ovf_o = st_r.ovf;
endmodule : pmon_ctr_unit

// >>> hw/pmon_evt_select.sv
`timescale 1ns/1ps
`include "pmon_regs.svh"

module pmon_evt_select
  import pmon_pkg::*;
(
  input wire evt_bus_t ev_i,
  input wire logic [7:0] code_i,
  input wire logic [7:0] umask_i,
  output logic [7:0] inc_o
);
  function automatic logic [7:0] pc8(input logic [7:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      c = c + {7'h00, v[i]};
    end
    return c;
  endfunction : pc8

  logic [7:0] inc;
  logic [5:0] psel;

  always_comb begin
    inc = 8'h00;
    psel = 6'h00;
    case (code_i)
      `EV_ACT: begin
        inc = pc8({1'b0, umask_i[6:4] & {ev_i.pch[1].act_uf, ev_i.pch[1].act_wr,
                   ev_i.pch[1].act_rd}, 1'b0, umask_i[2:0] & {ev_i.pch[0].act_uf,
                   ev_i.pch[0].act_wr, ev_i.pch[0].act_rd}});
      end
      `EV_ACT_BY_PRIO: begin
        for (int k = 0; k < 2; k++) begin
          psel = 6'h00;
          if (ev_i.pch[k].act_rd || ev_i.pch[k].act_uf) begin
            psel[ev_i.pch[k].activate_by_priority] = 1'b1;
          end else if (ev_i.pch[k].act_wr) begin
            psel[3 + ev_i.pch[k].activate_by_priority] = 1'b1;
          end
          if (umask_i[6 + k]) begin
            inc = inc + {7'h00, |(umask_i[5:0] & psel)};
          end
        end
      end
      `EV_CAS: begin
        // No major-mode gating; underfills are the only reads in write mode
        for (int k = 0; k < 2; k++) begin
          if (umask_i[6 + k]) begin
            inc = inc + pc8({2'b00, umask_i[5:0] & ev_i.pch[k].cas});
          end
        end
      end
      `EV_WQ_ALLOC: inc = {7'h00, ev_i.wq_alloc};
      `EV_WQ_NE: inc = {7'h00, ev_i.wq_ne};
      `EV_WQ_FULL0: inc = {7'h00, ev_i.pch[0].wq_full};
      `EV_WQ_FULL1: inc = {7'h00, ev_i.pch[1].wq_full};
      `EV_RQ_OCC0: inc = 8'(ev_i.pch[0].rq_occ);
      `EV_RQ_OCC1: inc = 8'(ev_i.pch[1].rq_occ);
      `EV_WQ_OCC0: inc = 8'(ev_i.pch[0].wq_occ);
      `EV_WQ_OCC1: inc = 8'(ev_i.pch[1].wq_occ);
      `EV_WQ_RD_MATCH: inc = {7'h00, ev_i.rd_match};
      `EV_WQ_WR_MATCH: inc = {7'h00, ev_i.wr_match};
      `EV_PRE: inc = pc8({6'h00, ev_i.pch[1].pre, ev_i.pch[0].pre});
      `EV_PRE_ALL: begin
        inc = pc8({6'h00, umask_i[1:0] & {ev_i.pch[1].pre_all, ev_i.pch[0].pre_all}});
      end
      `EV_REFRESH: inc = pc8(umask_i & ev_i.refresh);
      `EV_SELF_REF: inc = {7'h00, ev_i.self_ref};
      `EV_THROTTLE: inc = pc8(umask_i & ev_i.throttle);
      `EV_CRIT_THR: inc = {7'h00, ev_i.crit_throttle};
      `EV_CKE_ON: inc = pc8(umask_i & ev_i.cke_on);
      `EV_PPD: inc = {7'h00, ev_i.ppd};
      `EV_MAJOR_MODES: inc = {7'h00, |(umask_i[3:0] & ev_i.major_mode)};
      `EV_MODE_CHG0: inc = pc8(umask_i & ev_i.pch[0].mode_chg);
      `EV_MODE_CHG1: inc = pc8(umask_i & ev_i.pch[1].mode_chg);
      `EV_RDB_INS: inc = {7'h00, ev_i.rdb_insert};
      `EV_PREEMPT: inc = {7'h00, ev_i.preempt};
      `EV_SB_NE: inc = {7'h00, ev_i.sb_ne};
      `EV_SB_FULL: inc = {7'h00, ev_i.sb_full};
      `EV_SB_ACC: inc = {7'h00, ev_i.sb_access};
      `EV_SB_REJ: inc = {7'h00, ev_i.sb_refused};
      `EV_SB_OCC: inc = 8'(ev_i.sb_occ);
      `EV_SB_INS: inc = {7'h00, ev_i.sb_insert};
      `EV_SB_PF_INS: inc = {7'h00, ev_i.sb_pref_insert};
      `EV_SB_PF_OCC: inc = 8'(ev_i.sb_pref_occ);
      `EV_PM_RQ_OCC: inc = 8'(ev_i.pm_rq_occ);
      `EV_PM_RQ_NE: inc = {7'h00, ev_i.pm_rq_ne};
      `EV_PM_RQ_FULL: inc = {7'h00, ev_i.pm_rq_full};
      `EV_PM_RQ_INS: inc = {7'h00, ev_i.pm_rq_ins};
      `EV_PM_WQ_OCC: inc = 8'(ev_i.pm_wq_occ);
      `EV_PM_WQ_NE: inc = {7'h00, ev_i.pm_wq_ne};
      `EV_PM_WQ_FULL: inc = {7'h00, ev_i.pm_wq_full};
      `EV_PM_WQ_INS: inc = {7'h00, ev_i.pm_wq_ins};
      `EV_PM_WQ_FLUSH: inc = {7'h00, ev_i.pm_wq_flush};
      default: inc = 8'h00;
    endcase
  end

  assign inc_o = inc;
endmodule : pmon_evt_select

// >>> tb/pmon_evt_counter_sva.sv
`timescale 1ns/1ps
`include "pmon_regs.svh"
module pmon_evt_counter_sva
  import pmon_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 48
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  input wire logic [31:0] RDATA_O,
  input wire evt_bus_t EV_I,
  input wire logic [NUM_CTR-1:0] OVF_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  reset_clear_a: assert property ($fell(RST_I) |-> RDATA_O == 32'h0 && OVF_O == '0)
    else $error("outputs not clear after reset");
  hi_word_a: assert property (RE_I && (ADDR_I == 8'h44 || (ADDR_I[7:5] == 3'b001 && ADDR_I[2]))
    |=> RDATA_O[31:16] == 16'h0) else $error("counter high word has bits above 47");
  unmapped_zero_a: assert property (RE_I && ADDR_I == 8'hF0 |=> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  ctl_bits_a: assert property (RE_I && ADDR_I < 8'h10 && ADDR_I[1:0] == 2'b00
    |=> (RDATA_O & ~`CTL_GEN_MASK) == 32'h0) else $error("control readback has stray bits");
  fix_bits_a: assert property (RE_I && ADDR_I == 8'h10
    |=> (RDATA_O & ~`CTL_FIX_MASK) == 32'h0) else $error("fixed control has stray bits");
  ctl_echo_a: assert property (WE_I && ADDR_I == 8'h00 ##1 !WE_I ##1 RE_I && ADDR_I == 8'h00
    |=> RDATA_O == ($past(WDATA_I, 3) & `CTL_GEN_MASK)) else $error("control readback wrong");
  ovf_pulse_a: assert property (OVF_O != '0 |=> (OVF_O & $past(OVF_O)) == '0)
    else $error("overflow request longer than one cycle");
  rdata_hold_a: assert property (!RE_I |=> $stable(RDATA_O))
    else $error("read data moved without a read");
endmodule : pmon_evt_counter_sva

bind pmon_evt_counter pmon_evt_counter_sva #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_sva (
  .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WE_I(WE_I),
  .RE_I(RE_I), .RDATA_O(RDATA_O), .EV_I(EV_I), .OVF_O(OVF_O));

// >>> tb/pmon_evt_source.sv
`timescale 1ns/1ps
module pmon_evt_source
  import pmon_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  input wire evt_bus_t pat_i,
  output evt_bus_t ev_o,
  output logic busy_o
);
  logic [7:0] left_r;
  // Bus is quiet outside bursts, so any stray count shows up
  always_ff @(posedge clk_i) begin
    if (rst_i || (left_r == 8'h00 && !go_i)) begin
      ev_o <= '0;
      left_r <= 8'h00;
    end else if (go_i) begin
      ev_o <= '0;
      left_r <= len_i;
    end else begin
      ev_o <= pat_i;
      left_r <= left_r - 8'h01;
    end
  end
  assign busy_o = (left_r != 8'h00) || (ev_o != '0);
endmodule : pmon_evt_source

// >>> tb/memctl_event_select_counting_test.sv
`timescale 1ns/1ps
`include "pmon_regs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module memctl_event_select_counting_test import pmon_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic go = 1'b0;
  logic busy;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic [4:0] ovf;
  logic [7:0] k;
  evt_bus_t ev;
  evt_bus_t pat = '0;
  evt_bus_t q;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int ovf_seen = 0;
  // Event code in the upper byte, unit mask in the lower
  logic [15:0] sel [33] = '{16'h0201, 16'h0210, 16'h02FF, 16'h2841, 16'h28A0, 16'h2884,
    16'h05CF, 16'h05F0, 16'h05FF, 16'h0542, 16'h05C4, 16'h2000, 16'h1600, 16'h2200, 16'h8000,
    16'h8300, 16'h2300, 16'h2400, 16'h4402, 16'h45FF, 16'h0300, 16'h8600, 16'h4703, 16'h0704,
    16'h51FF, 16'h50FF, 16'h1700, 16'h0800, 16'hD400, 16'hD500, 16'hE800, 16'hE000, 16'h99FF};
  logic [7:0] incs [33] = '{8'h01, 8'h00, 8'h02, 8'h01, 8'h01, 8'h00, 8'h08, 8'h04, 8'h0C,
    8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h25, 8'h3F, 8'h01, 8'h00, 8'h01, 8'h02, 8'h01, 8'h01,
    8'h02, 8'h01, 8'h02, 8'h00, 8'h01, 8'h01, 8'h01, 8'h11, 8'h01, 8'h07, 8'h00};
  logic [7:0] ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h38, 8'h3C,
    8'h40, 8'h44, 8'hF0};

  always #10 clk = ~clk;

  pmon_evt_counter dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we),
    .RE_I(re), .RDATA_O(rdata), .EV_I(ev), .OVF_O(ovf));
  pmon_evt_source src (.clk_i(clk), .rst_i(rst), .go_i(go), .len_i(8'h03), .pat_i(pat),
    .ev_o(ev), .busy_o(busy));

  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles++;
    if (ovf[1] === 1'b1) ovf_seen++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Three-cycle burst of one pattern, then wait for the bus to go quiet
  task automatic fire(input evt_bus_t p);
    int n;
    n = 0;
    @(posedge clk);
    pat <= p;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : fire

  function automatic evt_bus_t mk(input int i);
    evt_bus_t p;
    p = '0;
    case (i)
      0, 1, 3: p.pch[0].act_rd = 1'b1;
      2: {p.pch[0].act_wr, p.pch[1].act_uf} = 2'b11;
      4, 5: begin
        p.pch[1].act_wr = 1'b1;
        p.pch[1].activate_by_priority = PRIO_STARVED;
      end
      6, 7, 8: {p.pch[0].cas, p.pch[1].cas} = 12'hFFF;
      9: {p.pch[0].cas, p.pch[1].cas} = 12'h082;
      10: {p.major_mode, p.pch[0].cas} = 10'h104;
      11: p.wq_alloc = 1'b1;
      12, 13: p.pch[1].wq_full = 1'b1;
      14: p.pch[0].rq_occ = 6'h25;
      15: p.pch[1].wq_occ = 6'h3F;
      16, 17: p.rd_match = 1'b1;
      18: p.pch[1].pre_all = 1'b1;
      19: p.refresh = 8'h12;
      20: p.pch[1].pre = 1'b1;
      21: p.crit_throttle = 1'b1;
      22: p.cke_on = 8'h0F;
      23: p.major_mode = 4'h5;
      24, 25: p.pch[1].mode_chg = 8'h81;
      26: p.rdb_insert = 1'b1;
      27: p.preempt = 1'b1;
      28: p.sb_refused = 1'b1;
      29: p.sb_occ = 6'h11;
      30: p.pm_wq_flush = 1'b1;
      31: p.pm_rq_occ = 6'h07;
      default: p = '1;
    endcase
    return p;
  endfunction : mk

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], rv);
      `CHK(rv, 32'h0)
    end
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, rv);
    `CHK(rv, `CTL_GEN_MASK)
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, rv);
    `CHK(rv, `CTL_FIX_MASK)
    wr(8'h10, 32'h0);
    // Fixed counter was enabled for four edges: two in the read and two in the disabling write
    rd(8'h40, rv);
    `CHK(rv, 32'h4)
    rd(8'h44, rv);
    `CHK(rv, 32'h0)
    // Rotate over the four general counters
    for (int i = 0; i < 33; i++) begin
      k = 8'(i % 4);
      wr(8'h20 + (k << 3), 32'h0);
      wr(8'h24 + (k << 3), 32'h0);
      wr(k << 2, 32'h0040_0000 | {16'h0, sel[i][7:0], sel[i][15:8]});
      fire(mk(i));
      wr(k << 2, 32'h0);
      rd(8'h20 + (k << 3), rv);
      `CHK(rv, 32'(incs[i]) * 32'h3)
    end
    q = '0;
    q.wq_alloc = 1'b1;
    wr(8'h28, 32'hFFFF_FFFF);
    wr(8'h2C, 32'h0000_FFFF);
    wr(8'h04, 32'h0050_0020);
    fire(q);
    wr(8'h04, 32'h0);
    rd(8'h28, rv);
    `CHK(rv, 32'h2)
    rd(8'h2C, rv);
    `CHK(rv, 32'h0)
    `CHK(ovf_seen, 1)
    wr(8'h04, 32'h0008_0000);
    rd(8'h28, rv);
    `CHK(rv, 32'h0)
    fire(q);
    rd(8'h28, rv);
    `CHK(rv, 32'h0)
    print_verdict();
  end
endmodule : memctl_event_select_counting_test
